// *** fsi_pkg.sv ***
// Constants, types and timing for the fault and status indicator block.
// Assumes a single 50 MHz system clock; all key and event inputs are synchronous to it.

package fsi_pkg;

	// ----------------------------------------------------------------
	// Timing.
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned SELFTEST_MS = 500;
	localparam int unsigned ACK_HOLD_MS = 3000;
	localparam int unsigned FLASH_ON_MS = 250;
	localparam int unsigned FLASH_OFF_MS = 250;
	localparam int unsigned FLASH_PAUSE_MS = 1500;
	localparam int unsigned SELFTEST_CYC = SELFTEST_MS * CYC_PER_MS;
	localparam int unsigned ACK_HOLD_CYC = ACK_HOLD_MS * CYC_PER_MS;
	localparam int unsigned FLASH_ON_CYC = FLASH_ON_MS * CYC_PER_MS;
	localparam int unsigned FLASH_OFF_CYC = FLASH_OFF_MS * CYC_PER_MS;
	localparam int unsigned FLASH_PAUSE_CYC = FLASH_PAUSE_MS * CYC_PER_MS;
	localparam int CNT_W = 28;

	// ----------------------------------------------------------------
	// Link voltage thresholds in volts (150 V and 300 V models).
	// ----------------------------------------------------------------
	localparam int DC_W = 10;
	localparam logic [DC_W-1:0] DC_LOW_LOWMAINS = 10'h096;
	localparam logic [DC_W-1:0] DC_LOW_HIGHMAINS = 10'h12c;

	// ----------------------------------------------------------------
	// Fault classes; bit index plus one is the flash count.
	// ----------------------------------------------------------------
	localparam int NUM_FAULTS = 9;
	localparam int FLT_MAINS = 1;
	localparam logic [NUM_FAULTS-1:0] ACK_MASK = 9'h0fc;
	localparam logic [NUM_FAULTS-1:0] MAINS_MASK = 9'h002;
	localparam logic [3:0] FLASH_NONE = 4'h0;
	localparam logic [3:0] FLASH_CPU = 4'h1;

	typedef struct packed {
		logic param_memory_fault;
		logic inverter_overtemp_fault;
		logic motor_overtemp_fault;
		logic inverter_overload_fault;
		logic motor_overload_fault;
		logic regenerative_excess_fault;
		logic overcurrent_fault;
		logic mains_loss_fault;
		logic cpu_fault;
	} fsi_fault_t;

	typedef struct packed {
		logic param_change;
		logic panel_ctrl;
		logic card_access;
	} fsi_req_t;

	typedef struct packed {
		logic card_memory_full;
		logic card_checksum_bad;
		logic card_link_broken;
		logic card_params_incompatible;
		logic card_type_wrong;
		logic card_validity_bad;
		logic card_write_protected;
	} fsi_card_t;

	typedef enum logic [2:0] {
		WARN_NONE = 3'h0,
		WARN_PARAM_CHANGE_RUNNING = 3'h1,
		WARN_PANEL_CONTROL_RUNNING = 3'h2,
		WARN_CARD_ACCESS_RUNNING = 3'h3,
		WARN_SYSTEM_ERROR = 3'h4,
		WARN_MOTOR_DATA_INCOMPLETE = 3'h5,
		WARN_PASSWORD_INVALID = 3'h6
	} fsi_warn_t;

	typedef enum logic [4:0] {
		ST_OFF = 5'h01,
		ST_TEST = 5'h02,
		ST_READY = 5'h04,
		ST_RUN = 5'h08,
		ST_FAULT = 5'h10
	} fsi_state_t;

	typedef enum logic [2:0] {
		FL_IDLE = 3'h1,
		FL_ON = 3'h2,
		FL_DARK = 3'h4
	} fsi_flash_t;

endpackage

// *** fsi_flash_gen.sv ***
// Flash group generator: lights the output count times, then a long pause.
// Assumes count_i stays in 1..15 while en_i is high; it is latched per group.
`timescale 1ns/1ns
`default_nettype none

module fsi_flash_gen #(
	parameter int unsigned ON_CYC = fsi_pkg::FLASH_ON_CYC,
	parameter int unsigned OFF_CYC = fsi_pkg::FLASH_OFF_CYC,
	parameter int unsigned PAUSE_CYC = fsi_pkg::FLASH_PAUSE_CYC
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Control.
	input wire logic en_i,
	input wire logic [3:0] count_i,
	// Indicator drive.
	output logic led_o
);
	import fsi_pkg::*;

	localparam logic [CNT_W-1:0] ON_LAST = CNT_W'(ON_CYC - 1);
	localparam logic [CNT_W-1:0] OFF_LAST = CNT_W'(OFF_CYC - 1);
	localparam logic [CNT_W-1:0] PAUSE_LAST = CNT_W'(PAUSE_CYC - 1);

	fsi_flash_t st_q, st_d;
	logic [CNT_W-1:0] tmr_q, tmr_d;
	logic [3:0] done_q, done_d;
	logic [3:0] grp_q, grp_d;
	logic led_q, led_d;

	// ------------------------------------------------------------
	// Flash sequencing.
	// ------------------------------------------------------------
	// The pause is six times a single dark gap so groups stay countable.
	always_comb begin
		st_d = st_q;
		tmr_d = tmr_q + 1'b1;
		done_d = done_q;
		grp_d = grp_q;
		case (st_q)
			FL_IDLE: begin
				tmr_d = '0;
				done_d = '0;
				grp_d = count_i;
				if (en_i) begin
					st_d = FL_ON;
				end
			end
			FL_ON: begin
				if (tmr_q == ON_LAST) begin
					st_d = FL_DARK;
					tmr_d = '0;
					done_d = done_q + 1'b1;
				end
			end
			FL_DARK: begin
				if ((done_q == grp_q && tmr_q == PAUSE_LAST) ||
				    (done_q != grp_q && tmr_q == OFF_LAST)) begin
					st_d = FL_ON;
					tmr_d = '0;
					if (done_q == grp_q) begin
						done_d = '0;
						grp_d = count_i;
					end
				end
			end
			default: begin
				st_d = FL_IDLE;
			end
		endcase
		if (!en_i) begin
			st_d = FL_IDLE;
		end
		led_d = (st_d == FL_ON);
	end

	// Registers only.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= FL_IDLE;
			tmr_q <= '0;
			done_q <= '0;
			grp_q <= '0;
			led_q <= 1'b0;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			done_q <= done_d;
			grp_q <= grp_d;
			led_q <= led_d;
		end
	end

	assign led_o = led_q;

endmodule

`default_nettype wire

// *** fsi_status_top.sv ***
// Fault and status indicator for a motor inverter: two LEDs, fault latch,
// acknowledge keys, warning and card error codes, refusal while running.
// Assumes keys are debounced and all inputs are synchronous to sys_clk_i.
`timescale 1ns/1ns
`default_nettype none

module fsi_status_top #(
	parameter int unsigned TEST_CYC = fsi_pkg::SELFTEST_CYC,
	parameter int unsigned ACK_CYC = fsi_pkg::ACK_HOLD_CYC,
	parameter int unsigned ON_CYC = fsi_pkg::FLASH_ON_CYC,
	parameter int unsigned OFF_CYC = fsi_pkg::FLASH_OFF_CYC,
	parameter int unsigned PAUSE_CYC = fsi_pkg::FLASH_PAUSE_CYC
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Drive state.
	input wire logic power_good_i,
	input wire logic run_cmd_i,
	input wire logic motor_running_i,
	input wire logic overload_active_i,
	input wire logic thermistor_fitted_i,
	input wire logic high_mains_model_i,
	input wire logic [fsi_pkg::DC_W-1:0] dc_link_voltage_i,
	// Fault and warning events, one-cycle pulses.
	input wire fsi_pkg::fsi_fault_t fault_ev_i,
	input wire fsi_pkg::fsi_req_t req_i,
	input wire logic sys_error_i,
	input wire logic motor_data_incomplete_i,
	input wire logic password_bad_i,
	input wire fsi_pkg::fsi_card_t card_err_i,
	// Panel keys, high while pressed.
	input wire logic key_stop_i,
	input wire logic key_enter_i,
	// Indicators and status.
	output logic green_indicator_o,
	output logic red_indicator_o,
	output logic ready_o,
	output logic [3:0] fault_class_o,
	output fsi_pkg::fsi_warn_t warn_code_o,
	output logic [2:0] card_code_o,
	output fsi_pkg::fsi_req_t grant_o
);
	import fsi_pkg::*;

	localparam logic [CNT_W-1:0] TEST_LAST = CNT_W'(TEST_CYC - 1);
	localparam logic [CNT_W-1:0] ACK_LAST = CNT_W'(ACK_CYC - 1);
	localparam logic [CNT_W-1:0] ACK_FULL = CNT_W'(ACK_CYC);

	fsi_state_t state_q, state_d;
	logic [CNT_W-1:0] test_q, test_d;
	logic [CNT_W-1:0] press_q, press_d;
	fsi_fault_t fault_q, fault_d;
	logic stop_prev_q, enter_prev_q;
	fsi_warn_t warn_q, warn_d;
	logic [2:0] card_q, card_d;
	logic green_q, green_d, red_q, red_d, ready_q, ready_d;
	logic [3:0] class_q, class_d;
	fsi_req_t grant_q, grant_d;
	logic ack, dc_low, stop_rise, enter_rise, warn_ev, flash_led;
	logic [NUM_FAULTS-1:0] ev_g, clr;

	// ------------------------------------------------------------
	// Key handling and fault latch.
	// ------------------------------------------------------------
	// A long stop press pulses ack once; releasing early restarts the count.
	always_comb begin
		press_d = '0;
		if (key_stop_i) begin
			press_d = (press_q == ACK_FULL) ? press_q : press_q + 1'b1;
		end
		ack = key_stop_i && (press_q == ACK_LAST);
		stop_rise = key_stop_i && !stop_prev_q;
		enter_rise = key_enter_i && !enter_prev_q;
		dc_low = dc_link_voltage_i < (high_mains_model_i ? DC_LOW_HIGHMAINS : DC_LOW_LOWMAINS);
		ev_g = fault_ev_i;
		ev_g[6] = fault_ev_i.motor_overtemp_fault && thermistor_fitted_i;
		// Processor and memory faults are outside the ack mask.
		clr = (ack ? ACK_MASK : '0) | (dc_low ? MAINS_MASK : '0);
		// New events win over a clear in the same cycle; power loss clears all.
		fault_d = power_good_i ? ((fault_q & ~clr) | ev_g) : '0;
		// Lowest flash count has priority; class is bit index plus one.
		class_d = FLASH_NONE;
		for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
			if (fault_q[i]) begin
				class_d = 4'(i + 1);
			end
		end
	end

	// ------------------------------------------------------------
	// Warnings, card codes and grants.
	// ------------------------------------------------------------
	// Running locks out operator actions and a system error blocks the panel.
	always_comb begin
		grant_d.param_change = req_i.param_change && !motor_running_i;
		grant_d.panel_ctrl = req_i.panel_ctrl && !motor_running_i && !sys_error_i;
		grant_d.card_access = req_i.card_access && !motor_running_i;
		warn_ev = 1'b1;
		if (motor_running_i && req_i.param_change) begin
			warn_d = WARN_PARAM_CHANGE_RUNNING;
		end else if (motor_running_i && req_i.panel_ctrl) begin
			warn_d = WARN_PANEL_CONTROL_RUNNING;
		end else if (motor_running_i && req_i.card_access) begin
			warn_d = WARN_CARD_ACCESS_RUNNING;
		end else if (sys_error_i) begin
			warn_d = WARN_SYSTEM_ERROR;
		end else if (motor_data_incomplete_i) begin
			warn_d = WARN_MOTOR_DATA_INCOMPLETE;
		end else if (password_bad_i) begin
			warn_d = WARN_PASSWORD_INVALID;
		end else begin
			warn_ev = 1'b0;
			warn_d = enter_rise ? WARN_NONE : warn_q;
		end
		// Card codes: first set bit wins, code is bit index plus one.
		card_d = stop_rise ? 3'h0 : card_q;
		for (int j = 6; j >= 0; j--) begin
			if (card_err_i[j]) begin
				card_d = 3'(j + 1);
			end
		end
		if (!power_good_i) begin
			warn_d = WARN_NONE;
			card_d = 3'h0;
			grant_d = '0;
		end
	end

	// ------------------------------------------------------------
	// Operating state and indicator drive.
	// ------------------------------------------------------------
	// Outputs are decoded from the current state and registered once.
	always_comb begin
		state_d = state_q;
		test_d = '0;
		green_d = 1'b0;
		red_d = 1'b0;
		case (state_q)
			ST_OFF: begin
				state_d = ST_TEST;
			end
			ST_TEST: begin
				red_d = 1'b1;
				test_d = test_q + 1'b1;
				if (test_q == TEST_LAST) begin
					state_d = ST_READY;
				end
			end
			ST_READY: begin
				green_d = overload_active_i;
				red_d = overload_active_i;
				if (fault_q != '0) begin
					state_d = ST_FAULT;
				end else if (run_cmd_i) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				green_d = 1'b1;
				red_d = overload_active_i;
				if (fault_q != '0) begin
					state_d = ST_FAULT;
				end else if (!run_cmd_i) begin
					state_d = ST_READY;
				end
			end
			ST_FAULT: begin
				red_d = flash_led;
				if (fault_q == '0) begin
					state_d = ST_READY;
				end
			end
			default: begin
				state_d = ST_OFF;
			end
		endcase
		if (!power_good_i) begin
			state_d = ST_OFF;
			green_d = 1'b0;
			red_d = 1'b0;
		end
		ready_d = power_good_i && (state_q == ST_READY || state_q == ST_RUN);
	end

	// One flash sequencer; it starts a fresh group whenever a fault is entered.
	fsi_flash_gen #(
		.ON_CYC(ON_CYC),
		.OFF_CYC(OFF_CYC),
		.PAUSE_CYC(PAUSE_CYC)
	) u_flash (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.en_i(state_q == ST_FAULT && class_q != FLASH_NONE),
		.count_i(class_q),
		.led_o(flash_led)
	);

	// Registers only.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= ST_OFF;
			test_q <= '0;
			press_q <= '0;
			fault_q <= '0;
			stop_prev_q <= 1'b0;
			enter_prev_q <= 1'b0;
			warn_q <= WARN_NONE;
			card_q <= 3'h0;
			green_q <= 1'b0;
			red_q <= 1'b0;
			ready_q <= 1'b0;
			class_q <= FLASH_NONE;
			grant_q <= '0;
		end else begin
			state_q <= state_d;
			test_q <= test_d;
			press_q <= press_d;
			fault_q <= fault_d;
			stop_prev_q <= key_stop_i;
			enter_prev_q <= key_enter_i;
			warn_q <= warn_d;
			card_q <= card_d;
			green_q <= green_d;
			red_q <= red_d;
			ready_q <= ready_d;
			class_q <= class_d;
			grant_q <= grant_d;
		end
	end

	assign green_indicator_o = green_q;
	assign red_indicator_o = red_q;
	assign ready_o = ready_q;
	assign fault_class_o = class_q;
	assign warn_code_o = warn_q;
	assign card_code_o = card_q;
	assign grant_o = grant_q;

	// ------------------------------------------------------------
	// Assertions and covers.
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	property p_off_dark;
		!power_good_i |=> !green_indicator_o && !red_indicator_o;
	endproperty
	a_off_dark: assert property (p_off_dark)
		else $error("Indicator lit while unpowered.");

	property p_test_red;
		power_good_i && state_q == ST_TEST |=> red_indicator_o && !green_indicator_o;
	endproperty
	a_test_red: assert property (p_test_red)
		else $error("Self-test indication wrong.");

	property p_run_green;
		power_good_i && state_q == ST_RUN && !overload_active_i |=> green_indicator_o && !red_indicator_o;
	endproperty
	a_run_green: assert property (p_run_green)
		else $error("Run indication wrong.");

	property p_overload_both;
		power_good_i && overload_active_i && (state_q == ST_RUN || state_q == ST_READY)
			|=> green_indicator_o && red_indicator_o;
	endproperty
	a_overload_both: assert property (p_overload_both)
		else $error("Overload indication wrong.");

	property p_fault_green_dark;
		state_q == ST_FAULT |=> !green_indicator_o;
	endproperty
	a_fault_green_dark: assert property (p_fault_green_dark)
		else $error("Green lit during fault.");

	property p_cpu_sticky;
		fault_q.cpu_fault && power_good_i |=> fault_q.cpu_fault ##0 fault_class_o == FLASH_CPU;
	endproperty
	a_cpu_sticky: assert property (p_cpu_sticky)
		else $error("Processor fault lost or not shown first.");

	property p_mains_clear;
		dc_low && !fault_ev_i.mains_loss_fault |=> !fault_q.mains_loss_fault;
	endproperty
	a_mains_clear: assert property (p_mains_clear)
		else $error("Mains fault kept below link threshold.");

	property p_no_thermistor;
		!thermistor_fitted_i && !fault_q.motor_overtemp_fault |=> !fault_q.motor_overtemp_fault;
	endproperty
	a_no_thermistor: assert property (p_no_thermistor)
		else $error("Motor overtemperature raised without thermistor.");

	property p_long_press;
		$fell(fault_q.overcurrent_fault) && $past(power_good_i)
			|-> $past(key_stop_i) && $past(press_q) == ACK_LAST;
	endproperty
	a_long_press: assert property (p_long_press)
		else $error("Fault cleared without a long stop press.");

	property p_refuse_param;
		power_good_i && motor_running_i && req_i.param_change
			|=> warn_code_o == WARN_PARAM_CHANGE_RUNNING && !grant_o.param_change;
	endproperty
	a_refuse_param: assert property (p_refuse_param)
		else $error("Parameter change not refused while running.");

	property p_warn_hold;
		power_good_i && !warn_ev && !enter_rise |=> $stable(warn_code_o);
	endproperty
	a_warn_hold: assert property (p_warn_hold)
		else $error("Warning changed without enter key.");

	property p_card_hold;
		power_good_i && card_err_i == '0 && !stop_rise |=> $stable(card_code_o);
	endproperty
	a_card_hold: assert property (p_card_hold)
		else $error("Card code changed without stop key.");

	c_selftest_done: cover property (state_q == ST_TEST ##1 state_q == ST_READY);
	c_fault_flash: cover property (state_q == ST_FAULT && red_indicator_o);
	c_fault_ack: cover property ($fell(fault_q.overcurrent_fault));
	c_warn_ack: cover property (warn_code_o != WARN_NONE ##1 warn_code_o == WARN_NONE);

endmodule

`default_nettype wire

// *** fsi_panel_model.sv ***
// Operator panel model: presses the two keys when told and reads the red flash groups.
// Assumes command inputs change just after a clock edge; one system clock only.
`timescale 1ns/1ns
`default_nettype none

module fsi_panel_model #(
	parameter int unsigned OFF_CYC = 4
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Operator intent from the bench.
	input wire logic stop_cmd_i,
	input wire logic enter_cmd_i,
	// Indicator seen by the operator.
	input wire logic red_indicator_i,
	// Keys and group reading.
	output logic key_stop_o,
	output logic key_enter_o,
	output logic group_done_o,
	output int group_cnt_o
);
	// ----------------------------------------------------------------
	// Keys and flash reading.
	// ----------------------------------------------------------------
	logic red_q;
	int dark_q;
	int run_q;

	// A dark spell more than two cycles longer than the gap between flashes marks a new group, so a short
	// pause would merge two groups and the reported count would come out wrong.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			key_stop_o <= 1'b0;
			key_enter_o <= 1'b0;
			group_done_o <= 1'b0;
			group_cnt_o <= 0;
			red_q <= 1'b0;
			dark_q <= 0;
			run_q <= 0;
		end else begin
			key_stop_o <= stop_cmd_i;
			key_enter_o <= enter_cmd_i;
			red_q <= red_indicator_i;
			group_done_o <= 1'b0;
			if (red_indicator_i && !red_q) begin
				if (dark_q > OFF_CYC + 2) begin
					group_cnt_o <= run_q;
					group_done_o <= 1'b1;
					run_q <= 1;
				end else begin
					run_q <= run_q + 1;
				end
			end
			if (red_indicator_i) begin
				dark_q <= 0;
			end else begin
				dark_q <= dark_q + 1;
			end
		end
	end

endmodule
`default_nettype wire

// *** fault_status_indicator_tb.sv ***
// Self-checking bench for the fault and status indicator with short timing parameters.
// Assumes the panel model in its own file; expectations come from a mask of latched faults.
`timescale 1ns/1ns
`default_nettype none

module fault_status_indicator_tb;
	import fsi_pkg::*;

	// ----------------------------------------------------------------
	// Signals and instances.
	// ----------------------------------------------------------------
	localparam int unsigned T_CYC = 20;
	localparam int unsigned A_CYC = 30;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic power_good, run_cmd, motor_running, overload, thermistor, high_mains;
	logic [DC_W-1:0] dc_volt;
	fsi_fault_t fault_ev;
	fsi_req_t req, grant;
	fsi_card_t card_err;
	logic sys_error, mdata_bad, pwd_bad, stop_cmd, enter_cmd, key_stop, key_enter;
	logic green, red, ready, group_done;
	logic [3:0] fclass;
	fsi_warn_t warn;
	logic [2:0] card_code;
	int group_cnt;
	int error_cnt = 0;
	int num_checks = 0;
	int fmask = 0;

	// Free-running 50 MHz system clock.
	always #10 sys_clk_i = ~sys_clk_i;

	fsi_status_top #(.TEST_CYC(T_CYC), .ACK_CYC(A_CYC), .ON_CYC(4), .OFF_CYC(4), .PAUSE_CYC(24)) uut (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .power_good_i(power_good), .run_cmd_i(run_cmd),
		.motor_running_i(motor_running), .overload_active_i(overload), .thermistor_fitted_i(thermistor),
		.high_mains_model_i(high_mains), .dc_link_voltage_i(dc_volt), .fault_ev_i(fault_ev), .req_i(req),
		.sys_error_i(sys_error), .motor_data_incomplete_i(mdata_bad), .password_bad_i(pwd_bad),
		.card_err_i(card_err), .key_stop_i(key_stop), .key_enter_i(key_enter), .green_indicator_o(green),
		.red_indicator_o(red), .ready_o(ready), .fault_class_o(fclass), .warn_code_o(warn),
		.card_code_o(card_code), .grant_o(grant));

	fsi_panel_model #(.OFF_CYC(4)) panel (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .stop_cmd_i(stop_cmd), .enter_cmd_i(enter_cmd),
		.red_indicator_i(red), .key_stop_o(key_stop), .key_enter_o(key_enter),
		.group_done_o(group_done), .group_cnt_o(group_cnt));

	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask

	// Lowest latched class wins, so the shown flash count is its index plus one.
	function automatic int exp_class();
		for (int i = 0; i < 9; i++) begin
			if (fmask[i]) begin
				return i + 1;
			end
		end
		return 0;
	endfunction

	task automatic power_up();
		int n;
		n = 0;
		power_good <= 1'b1;
		cyc(4);
		chk({green, red, ready}, 3'b010);
		while (ready !== 1'b1 && n < 4 * T_CYC) begin
			cyc(1);
			n++;
		end
		if (ready !== 1'b1) begin
			error_cnt++;
			report_and_stop();
		end
		chk(n > T_CYC - 5, 1'b1);
		cyc(1);
		chk({green, red}, 2'b00);
	endtask

	task automatic press(input logic stop, input int n);
		stop_cmd <= stop;
		enter_cmd <= !stop;
		cyc(n);
		stop_cmd <= 1'b0;
		enter_cmd <= 1'b0;
		cyc(4);
	endtask

	// One request or warning event; grants are gathered over the answer window.
	task automatic do_warn(input logic [2:0] rq, input int ev, input logic run, input int exp_w);
		logic [2:0] g;
		g = 3'h0;
		motor_running <= run;
		cyc(1);
		req <= fsi_req_t'(rq);
		sys_error <= (ev == 4);
		mdata_bad <= (ev == 5);
		pwd_bad <= (ev == 6);
		cyc(1);
		req <= 3'h0;
		sys_error <= 1'b0;
		mdata_bad <= 1'b0;
		pwd_bad <= 1'b0;
		repeat (3) begin
			cyc(1);
			g = g | grant;
		end
		chk(warn, exp_w);
		chk(g, run ? 3'h0 : (ev == 4 ? (rq & 3'b101) : rq));
		press(1'b0, 2);
		chk(warn, WARN_NONE);
	endtask

	// Waits for two group boundaries; the second reports the first whole group.
	task automatic flash_grp(input int exp);
		int got;
		int n;
		got = 0;
		n = 0;
		while (got < 2 && n < 800) begin
			cyc(1);
			n++;
			if (group_done === 1'b1) begin
				got++;
			end
		end
		if (got < 2) begin
			error_cnt++;
			report_and_stop();
		end
		chk(group_cnt, exp);
	endtask

	task automatic fault(input logic [8:0] bits);
		fault_ev <= fsi_fault_t'(bits);
		cyc(1);
		fault_ev <= 9'h000;
		cyc(4);
	endtask

	task automatic power_cycle();
		power_good <= 1'b0;
		cyc(4);
		chk({green, red, fclass}, 6'h00);
		fmask = 0;
		power_up();
	endtask

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h9148));
		{power_good, run_cmd, motor_running, overload, thermistor, high_mains} = 6'h00;
		{sys_error, mdata_bad, pwd_bad, stop_cmd, enter_cmd} = 5'h00;
		dc_volt = 10'h3e7;
		fault_ev = 9'h000;
		req = 3'h0;
		card_err = 7'h00;
		cyc(12);
		rst_i <= 1'b0;
		cyc(4);
		chk({green, red, ready}, 3'b000);
		high_mains <= 1'b1;
		dc_volt <= 10'(300 + $urandom % 700);
		power_up();
		run_cmd <= 1'b1;
		cyc(4);
		chk({green, red}, 2'b10);
		overload <= 1'b1;
		cyc(4);
		chk({green, red}, 2'b11);
		overload <= 1'b0;
		run_cmd <= 1'b0;
		cyc(4);
		for (int k = 0; k < 3; k++) begin
			do_warn(3'b100 >> k, 0, 1'b1, k + 1);
			do_warn(3'b100 >> k, 0, 1'b0, 0);
		end
		for (int k = 4; k < 7; k++) begin
			do_warn(3'b010, k, 1'b0, k);
		end
		for (int c = 0; c < 7; c++) begin
			card_err <= fsi_card_t'(7'h01 << c);
			cyc(1);
			card_err <= 7'h00;
			cyc(3);
			chk(card_code, c + 1);
			press(1'b1, 2);
			chk(card_code, 0);
		end
		// Overtemperature of the motor is ignored without the sensor option.
		fault(9'h040);
		chk(fclass, 0);
		thermistor <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			fault(9'h001 << i);
			fmask = 1 << i;
			chk(fclass, exp_class());
			chk(green, 1'b0);
			flash_grp(i + 1);
			press(1'b1, 2 + $urandom % (A_CYC - 5));
			chk(fclass, exp_class());
			if (i == 1) begin
				dc_volt <= 10'd300;
				cyc(4);
				chk(fclass, exp_class());
				dc_volt <= 10'd299;
				cyc(4);
				fmask = 0;
				chk(fclass, 0);
			end else begin
				press(1'b1, A_CYC + 2);
				if (i >= 2 && i <= 7) begin
					fmask = 0;
				end
				chk(fclass, exp_class());
			end
			if (fmask != 0) begin
				power_cycle();
			end
			dc_volt <= 10'(300 + $urandom % 700);
		end
		// Two faults together: the lower class shows until acknowledged.
		fault(9'h104);
		fmask = 'h104;
		chk(fclass, exp_class());
		press(1'b1, A_CYC + 2);
		fmask = 'h100;
		chk(fclass, exp_class());
		power_cycle();
		// Low-mains model: the mains fault only ends below the lower threshold.
		high_mains <= 1'b0;
		dc_volt <= 10'd150;
		fault(9'h002);
		fmask = 'h002;
		chk(fclass, exp_class());
		dc_volt <= 10'd149;
		cyc(4);
		fmask = 0;
		chk(fclass, exp_class());
		// A reset in mid-run darkens everything and restarts the self-test.
		rst_i <= 1'b1;
		cyc(3);
		chk({green, red, ready, fclass}, 7'h00);
		rst_i <= 1'b0;
		power_up();
		report_and_stop();
	end

endmodule
`default_nettype wire
